// ===== frp_call_core.sv
// Purpose: Engine for the fuse-byte read and flash row-program calls.
// Assumes: Fuse, SRAM, protection and flash macro run on sys_clk.
// Notes: Start a call by writing the data word, then the doorbell.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "frp_consts.svh"
module frp_call_core import frp_pkg::*; #(
  parameter int ROW_BYTES = `FRP_ROW_BYTES,
  parameter int IW = $clog2(ROW_BYTES / 4)
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // AXI4-Lite register slave.
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Parameter block port into SRAM.
  output logic sram_req_q,
  output logic sram_we_q,
  output logic [31:0] sram_addr_q,
  output logic [31:0] sram_wdata_q,
  input wire logic sram_ack,
  input wire logic [31:0] sram_rdata,
  // Fuse array.
  output logic fuse_rd_q,
  output logic [15:0] fuse_addr_q,
  input wire logic fuse_ack,
  input wire logic [7:0] fuse_cell_intact,
  // Memory protection verdict for the caller.
  input wire logic flash_wr_allowed,
  // Flash macro control and events.
  output logic fl_erase_start_q,
  output logic fl_prog_start_q,
  output logic [31:0] fl_row_addr_q,
  output logic fl_hv_by_hw_q,
  output logic fl_stall_reads_q,
  input wire logic fl_erase_done,
  input wire logic fl_prog_done,
  input wire logic fl_prog_ok,
  // Row verify reads of flash and row latch.
  output logic fv_rd,
  output logic [31:0] fv_addr,
  input wire logic [31:0] fv_flash_word,
  output logic [IW-1:0] latch_idx,
  input wire logic [31:0] latch_word,
  // Caller status.
  output logic call_held_q,
  output logic call_returned_q
);
  frp_regs_if rif ();
  frp_state_e state_q;
  frp_state_e state_d;
  logic [31:0] w0_q;
  logic [31:0] w1_q;
  logic [31:0] ptr_q;
  logic [1:0] fidx_q;
  logic direct_q;
  logic done_q;
  logic [31:0] result_q;
  logic hw_we_q;
  logic vfy_start_q;
  logic vfy_done;
  logic vfy_mismatch;
  logic rif_hw_we_d;
  ////////////////////////////////////////////////////////////////////////
  // Decode of the call words.
  wire [7:0] opcode = w0_q[`FRP_OPC_HI:`FRP_OPC_LO];
  wire is_fuse = opcode == `FRP_OP_FUSE;
  wire is_row = opcode == `FRP_OP_ROW;
  wire blocking = w0_q[`FRP_BLK_HI:`FRP_BLK_LO] == `FRP_BLOCKING;
  wire vfy_en = w1_q[`FRP_VFY_HI:`FRP_VFY_LO] == `FRP_VFY_ON;
  wire call_direct = rif.call_data[`FRP_DIRECT_BIT];
  wire can_start = rif.start && state_q == S_IDLE;
  wire fetch_last = !is_row || fidx_q == 2'd2;
  wire [31:0] fuse_res = {`FRP_ST_OK, 20'h00000, ~fuse_cell_intact};
  wire [31:0] row_mask = ~(32'(ROW_BYTES) - 32'd1);
  wire [31:0] sram_fetch_addr = ptr_q + {28'h0000000, fidx_q, 2'b00};
  wire flash_busy = state_q == S_ERASE || state_q == S_PROG ||
    state_q == S_VERIFY;
  assign rif.hw_we = hw_we_q;
  assign rif.hw_data = result_q;
  assign rif.held = state_q != S_IDLE;
  assign rif.status = {24'h000000, state_q, 1'b0, done_q,
    call_returned_q, call_held_q};
  ////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (can_start) begin
          state_d = call_direct ? S_DECODE : S_FETCH;
        end
      end
      S_FETCH: begin
        if (sram_req_q && sram_ack && fidx_q != 2'd0 && fetch_last) begin
          state_d = S_DECODE;
        end else if (sram_req_q && sram_ack && fidx_q == 2'd0 &&
                     sram_rdata[`FRP_OPC_HI:`FRP_OPC_LO] != `FRP_OP_ROW) begin
          state_d = S_DECODE;
        end
      end
      S_DECODE: begin
        if (is_fuse) begin
          state_d = S_FUSE;
        end else if (is_row && !direct_q && flash_wr_allowed) begin
          state_d = S_ERASE;
        end else begin
          state_d = S_RESULT;
        end
      end
      S_FUSE: begin
        if (fuse_ack) begin
          state_d = S_RESULT;
        end
      end
      S_ERASE: begin
        if (fl_erase_done) begin
          state_d = S_PROG;
        end
      end
      S_PROG: begin
        if (fl_prog_done) begin
          state_d = (fl_prog_ok && vfy_en) ? S_VERIFY : S_RESULT;
        end
      end
      S_VERIFY: begin
        if (vfy_done) begin
          state_d = S_RESULT;
        end
      end
      S_RESULT: begin
        if (direct_q || (sram_req_q && sram_ack)) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end
  assign rif_hw_we_d = state_q == S_RESULT && direct_q && !hw_we_q;
  ////////////////////////////////////////////////////////////////////////
  // Call sequencing.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      w0_q <= 32'h0000_0000;
      w1_q <= 32'h0000_0000;
      ptr_q <= 32'h0000_0000;
      fidx_q <= 2'd0;
      direct_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= 32'h0000_0000;
      hw_we_q <= 1'b0;
      vfy_start_q <= 1'b0;
      sram_req_q <= 1'b0;
      sram_we_q <= 1'b0;
      sram_addr_q <= 32'h0000_0000;
      sram_wdata_q <= 32'h0000_0000;
      fuse_rd_q <= 1'b0;
      fuse_addr_q <= 16'h0000;
      fl_erase_start_q <= 1'b0;
      fl_prog_start_q <= 1'b0;
      fl_row_addr_q <= 32'h0000_0000;
      fl_hv_by_hw_q <= 1'b0;
      fl_stall_reads_q <= 1'b0;
      call_held_q <= 1'b0;
      call_returned_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hw_we_q <= rif_hw_we_d;
      fl_erase_start_q <= 1'b0;
      fl_prog_start_q <= 1'b0;
      vfy_start_q <= 1'b0;
      fuse_rd_q <= 1'b0;
      call_held_q <= state_d != S_IDLE;
      // Stall only on request; otherwise other sectors stay readable.
      fl_stall_reads_q <= w0_q[`FRP_STALL_BIT] && flash_busy;
      if (can_start) begin
        direct_q <= call_direct;
        done_q <= 1'b0;
        call_returned_q <= 1'b0;
        fidx_q <= 2'd0;
        if (call_direct) begin
          w0_q <= rif.call_data;
        end else begin
          // The low two address bits are dropped to keep words aligned.
          ptr_q <= {rif.call_data[31:2], 2'b00};
          sram_req_q <= 1'b1;
          sram_we_q <= 1'b0;
          sram_addr_q <= {rif.call_data[31:2], 2'b00};
        end
      end
      if (state_q == S_FETCH && sram_req_q && sram_ack) begin
        if (fidx_q == 2'd0) begin
          // Only the row call reads bits 2:1; the fuse call ignores them.
          w0_q <= sram_rdata;
        end else if (fidx_q == 2'd1) begin
          w1_q <= sram_rdata;
        end else begin
          fl_row_addr_q <= sram_rdata & row_mask;
        end
        sram_req_q <= state_d == S_FETCH;
        sram_addr_q <= sram_fetch_addr + 32'd4;
        fidx_q <= fidx_q + 2'd1;
      end
      if (state_q == S_DECODE) begin
        if (is_fuse) begin
          fuse_rd_q <= 1'b1;
          fuse_addr_q <= w0_q[`FRP_FADDR_HI:`FRP_FADDR_LO];
        end else if (state_d == S_ERASE) begin
          fl_erase_start_q <= 1'b1;
          fl_hv_by_hw_q <= w0_q[`FRP_HVHW_BIT];
          call_returned_q <= !blocking;
        end else if (!is_row) begin
          result_q <= `FRP_ERR_OPCODE;
        end else if (direct_q) begin
          result_q <= `FRP_ERR_PARAM;
        end else begin
          result_q <= `FRP_ERR_PROT;
        end
      end
      if (state_q == S_FUSE && fuse_ack) begin
        result_q <= fuse_res;
      end
      if (state_q == S_ERASE && fl_erase_done) begin
        fl_prog_start_q <= 1'b1;
      end
      if (state_q == S_PROG && fl_prog_done) begin
        if (!fl_prog_ok) begin
          result_q <= `FRP_ERR_PROG;
        end else if (vfy_en) begin
          vfy_start_q <= 1'b1;
        end else begin
          result_q <= `FRP_RES_OK;
        end
      end
      if (state_q == S_VERIFY && vfy_done) begin
        result_q <= vfy_mismatch ? `FRP_ERR_VERIFY : `FRP_RES_OK;
      end
      if (state_q == S_RESULT && !direct_q && !sram_we_q) begin
        sram_req_q <= 1'b1;
        sram_we_q <= 1'b1;
        sram_addr_q <= ptr_q;
      end
      if (state_q == S_RESULT) begin
        sram_wdata_q <= result_q;
      end
      if (state_q == S_RESULT && sram_req_q && sram_ack) begin
        sram_req_q <= 1'b0;
        sram_we_q <= 1'b0;
      end
      if (state_q == S_RESULT && state_d == S_IDLE) begin
        done_q <= 1'b1;
        call_returned_q <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Register slave and row compare.
  frp_axil_regs u_regs (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .awaddr(s_axil_awaddr),
    .awvalid(s_axil_awvalid),
    .awready(s_axil_awready),
    .wdata(s_axil_wdata),
    .wstrb(s_axil_wstrb),
    .wvalid(s_axil_wvalid),
    .wready(s_axil_wready),
    .bresp(s_axil_bresp),
    .bvalid(s_axil_bvalid),
    .bready(s_axil_bready),
    .araddr(s_axil_araddr),
    .arvalid(s_axil_arvalid),
    .arready(s_axil_arready),
    .rdata(s_axil_rdata),
    .rresp(s_axil_rresp),
    .rvalid(s_axil_rvalid),
    .rready(s_axil_rready),
    .rif(rif.slave_side)
  );
  frp_row_verify #(
    .ROW_BYTES(ROW_BYTES),
    .IW(IW)
  ) u_verify (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(vfy_start_q),
    .row_base(fl_row_addr_q),
    .rd(fv_rd),
    .rd_addr(fv_addr),
    .latch_idx(latch_idx),
    .flash_word(fv_flash_word),
    .latch_word(latch_word),
    .done(vfy_done),
    .mismatch(vfy_mismatch)
  );
endmodule
`default_nettype wire

// ===== frp_consts.svh
// Purpose: Offsets, fields, codes and sizes of the fuse and row calls.
// Assumes: Included by its bare name.
// Notes: Definitions only.
`ifndef FRP_CONSTS_SVH
`define FRP_CONSTS_SVH
`define FRP_OFS_DATA 8'h00
`define FRP_OFS_CTRL 8'h04
`define FRP_OFS_STAT 8'h08
`define FRP_CTRL_START 0
`define FRP_OPC_HI 31
`define FRP_OPC_LO 24
`define FRP_FADDR_HI 23
`define FRP_FADDR_LO 8
`define FRP_DIRECT_BIT 0
`define FRP_HVHW_BIT 1
`define FRP_STALL_BIT 2
`define FRP_BLK_HI 15
`define FRP_BLK_LO 8
`define FRP_VFY_HI 23
`define FRP_VFY_LO 16
`define FRP_OP_FUSE 8'h03
`define FRP_OP_ROW 8'h05
`define FRP_BLOCKING 8'h01
`define FRP_VFY_ON 8'h01
`define FRP_ST_OK 4'ha
`define FRP_ST_ERR 4'hf
`define FRP_RES_OK 32'ha000_0000
`define FRP_ERR_VERIFY 32'hf000_0022
`define FRP_ERR_PROT 32'hf000_0010
`define FRP_ERR_PARAM 32'hf000_0011
`define FRP_ERR_OPCODE 32'hf000_0012
`define FRP_ERR_PROG 32'hf000_0013
`define FRP_ROW_BYTES 512
`define FRP_RESP_OKAY 2'b00
`define FRP_RESP_SLVERR 2'b10
`endif

// ===== frp_pkg.sv
// Purpose: Types shared by the fuse and row call logic.
// Assumes: Nothing.
// Notes: Constants live in frp_consts.svh.
package frp_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_FETCH = 4'b0001,
    S_DECODE = 4'b0010,
    S_FUSE = 4'b0011,
    S_ERASE = 4'b0100,
    S_PROG = 4'b0101,
    S_VERIFY = 4'b0110,
    S_RESULT = 4'b0111
  } frp_state_e;
  typedef logic [31:0] frp_word_t;
endpackage

// ===== frp_regs_if.sv
// Purpose: Carrier between the register slave and the call engine.
// Assumes: One clock.
// Notes: The engine's write to the data word wins over software.
`timescale 1ns/1ps
`default_nettype none
interface frp_regs_if;
  logic [31:0] call_data;
  logic start;
  logic hw_we;
  logic [31:0] hw_data;
  logic [31:0] status;
  logic held;
  modport slave_side (output call_data, output start,
    input hw_we, input hw_data, input status, input held);
  modport core_side (input call_data, input start,
    output hw_we, output hw_data, output status, output held);
endinterface
`default_nettype wire

// ===== frp_axil_regs.sv
// Purpose: AXI4-Lite slave holding the call data word, doorbell, status.
// Assumes: One write and one read at a time; 32-bit aligned words.
// Notes: Unmapped addresses answer SLVERR and read zero.
`timescale 1ns/1ps
`default_nettype none
`include "frp_consts.svh"
module frp_axil_regs import frp_pkg::*; (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Write channels.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Engine side.
  frp_regs_if.slave_side rif
);
  logic [7:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic w_have_q;
  logic [31:0] data_q;
  logic start_q;
  wire do_wr = aw_have_q && w_have_q && !bvalid;
  wire wr_data = do_wr && aw_q == `FRP_OFS_DATA;
  wire wr_ctrl = do_wr && aw_q == `FRP_OFS_CTRL;
  wire wr_ok = wr_data || wr_ctrl;
  wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}},
    {8{ws_q[0]}}};
  wire [31:0] rd_mux = araddr == `FRP_OFS_DATA ? data_q :
    araddr == `FRP_OFS_STAT ? rif.status : 32'h0000_0000;
  wire rd_ok = araddr == `FRP_OFS_DATA || araddr == `FRP_OFS_STAT ||
    araddr == `FRP_OFS_CTRL;
  assign awready = !aw_have_q;
  assign wready = !w_have_q;
  assign arready = !rvalid;
  assign rif.call_data = data_q;
  assign rif.start = start_q;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_q <= 8'h00;
      aw_have_q <= 1'b0;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      w_have_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `FRP_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `FRP_RESP_OKAY;
      data_q <= 32'h0000_0000;
      start_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_q <= awaddr;
        aw_have_q <= 1'b1;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q <= wdata;
        ws_q <= wstrb;
        w_have_q <= 1'b1;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? `FRP_RESP_OKAY : `FRP_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      start_q <= wr_ctrl && ws_q[0] && w_q[`FRP_CTRL_START];
      // Software may not rewrite the word while a call holds it.
      if (rif.hw_we) begin
        data_q <= rif.hw_data;
      end else if (wr_data && !rif.held) begin
        data_q <= (data_q & ~wmask) | (w_q & wmask);
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_ok ? `FRP_RESP_OKAY : `FRP_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== frp_row_verify.sv
// Purpose: Compares a programmed flash row with the row latch.
// Assumes: Flash and latch data arrive one cycle after their address.
// Notes: One word per cycle; done pulses after the last compare.
`timescale 1ns/1ps
`default_nettype none
`include "frp_consts.svh"
module frp_row_verify import frp_pkg::*; #(
  parameter int ROW_BYTES = `FRP_ROW_BYTES,
  parameter int IW = $clog2(ROW_BYTES / 4)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [31:0] row_base,
  output logic rd,
  output logic [31:0] rd_addr,
  output logic [IW-1:0] latch_idx,
  input wire logic [31:0] flash_word,
  input wire logic [31:0] latch_word,
  output logic done,
  output logic mismatch
);
  localparam logic [IW-1:0] LAST = IW'(ROW_BYTES / 4 - 1);
  logic busy_q;
  logic [IW-1:0] idx_q;
  logic pend_q;
  logic last_q;
  wire [31:0] next_addr = row_base + {{(30 - IW){1'b0}}, idx_q, 2'b00};
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      idx_q <= '0;
      pend_q <= 1'b0;
      last_q <= 1'b0;
      rd <= 1'b0;
      rd_addr <= 32'h0000_0000;
      latch_idx <= '0;
      done <= 1'b0;
      mismatch <= 1'b0;
    end else begin
      rd <= busy_q;
      pend_q <= rd;
      last_q <= rd && latch_idx == LAST;
      done <= pend_q && last_q;
      if (busy_q) begin
        rd_addr <= next_addr;
        latch_idx <= idx_q;
        idx_q <= idx_q + 1'b1;
        busy_q <= idx_q != LAST;
      end
      if (start) begin
        busy_q <= 1'b1;
        idx_q <= '0;
        mismatch <= 1'b0;
      end else if (pend_q && flash_word != latch_word) begin
        mismatch <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== frp_call_chk.sv
// Purpose: Port checks of the fuse and row call engine.
// Assumes: One clock; nrst is asynchronous and active low.
// Notes: Bound into frp_call_core by the statement at the foot.
`timescale 1ns/1ps
`default_nettype none
module frp_call_chk (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Engine ports and flash events.
  input wire logic call_held_q,
  input wire logic sram_req_q,
  input wire logic sram_ack,
  input wire logic [31:0] sram_addr_q,
  input wire logic flash_wr_allowed,
  input wire logic fl_erase_start_q,
  input wire logic fl_prog_start_q,
  input wire logic [31:0] fl_row_addr_q,
  input wire logic fl_stall_reads_q,
  input wire logic fl_erase_done,
  input wire logic fl_prog_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic erased_q;
  logic [1:0] erases_q;
  //////////////////////////////////////////////////////////////////////////
  // Cleared only when the channel is free, so a nested call shows up.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {erased_q, erases_q} <= 3'd0;
    end else if (!call_held_q) begin
      {erased_q, erases_q} <= 3'd0;
    end else begin
      if (fl_erase_done) erased_q <= 1'b1;
      if (fl_erase_start_q && erases_q != 2'd3) erases_q <= erases_q + 2'd1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  sequence s_prog_launch;
    ##[1:8] fl_prog_start_q;
  endsequence
  sequence s_released;
    ##[1:800] !call_held_q;
  endsequence
  AST_ERASE_TO_PROG: assert property (fl_erase_done |->
    s_prog_launch)
    else $error("Programming did not follow erase completion.");
  AST_PROG_AFTER_ERASE: assert property (fl_prog_start_q |-> erased_q)
    else $error("Programming started before the erase finished.");
  AST_RELEASE: assert property (fl_prog_done |-> s_released)
    else $error("Channel not released after programming.");
  AST_PROT: assert property (fl_erase_start_q |-> flash_wr_allowed)
    else $error("Erase started without write access.");
  AST_ROW: assert property (fl_erase_start_q |->
    fl_row_addr_q[8:0] == 9'h000)
    else $error("Row address not on a row boundary.");
  AST_ONE_CALL: assert property (erases_q < 2'd2)
    else $error("A second call started while one was pending.");
  AST_STALL: assert property (fl_stall_reads_q |-> call_held_q)
    else $error("Flash reads stalled with no call running.");
  AST_SRAM_HOLD: assert property (sram_req_q && !sram_ack |=>
    sram_req_q && $stable(sram_addr_q))
    else $error("Memory request dropped before its answer.");
endmodule
bind frp_call_core frp_call_chk u_chk (.*);
`default_nettype wire

// ===== frp_env_model.sv
// Purpose: Memory, fuse array and flash macro around the call engine.
// Assumes: All of them run on sys_clk.
// Notes: Released data lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module frp_env_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Bench controls and observations.
  input wire logic slow,
  input wire logic prog_ok,
  input wire logic corrupt,
  output logic ret_seen,
  output logic hv_seen,
  // Parameter block memory.
  input wire logic sram_req_q,
  input wire logic sram_we_q,
  input wire logic [31:0] sram_addr_q,
  input wire logic [31:0] sram_wdata_q,
  output logic sram_ack,
  output logic [31:0] sram_rdata,
  // Fuse array.
  input wire logic fuse_rd_q,
  input wire logic [15:0] fuse_addr_q,
  output logic fuse_ack,
  output logic [7:0] fuse_cell_intact,
  // Flash macro and row latch.
  input wire logic fl_erase_start_q,
  input wire logic fl_prog_start_q,
  input wire logic fl_hv_by_hw_q,
  input wire logic call_returned_q,
  output logic fl_erase_done,
  output logic fl_prog_done,
  output logic fl_prog_ok,
  input wire logic fv_rd,
  input wire logic [31:0] fv_addr,
  input wire logic [6:0] latch_idx,
  output logic [31:0] fv_flash_word,
  output logic [31:0] latch_word
);
  logic [31:0] mem [0:63];
  logic [1:0] wait_q;
  logic fuse_p_q;
  logic [4:0] ecnt_q;
  logic [4:0] pcnt_q;
  //////////////////////////////////////////////////////////////////////////
  // Slow mode stretches every memory access by three cycles.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sram_ack <= 1'b0;
      wait_q <= 2'd0;
      fuse_p_q <= 1'b0;
      fuse_ack <= 1'b0;
      ecnt_q <= 5'd0;
      pcnt_q <= 5'd0;
      fl_erase_done <= 1'b0;
      fl_prog_done <= 1'b0;
    end else begin
      sram_ack <= 1'b0;
      sram_rdata <= ~sram_rdata;
      if (sram_req_q && !sram_ack) begin
        if (wait_q >= (slow ? 2'd3 : 2'd0)) begin
          sram_ack <= 1'b1;
          wait_q <= 2'd0;
          if (sram_we_q) mem[sram_addr_q[7:2]] <= sram_wdata_q;
          else sram_rdata <= mem[sram_addr_q[7:2]];
        end else wait_q <= wait_q + 2'd1;
      end
      fuse_p_q <= fuse_rd_q;
      fuse_ack <= fuse_p_q;
      fuse_cell_intact <= fuse_p_q ? fuse_addr_q[7:0] ^ 8'h5a :
        ~fuse_cell_intact;
      ecnt_q <= fl_erase_start_q ? 5'd20 : ecnt_q - {4'd0, ecnt_q != 0};
      pcnt_q <= fl_prog_start_q ? 5'd20 : pcnt_q - {4'd0, pcnt_q != 0};
      fl_erase_done <= ecnt_q == 5'd1;
      fl_prog_done <= pcnt_q == 5'd1;
      fl_prog_ok <= prog_ok;
      if (fl_erase_start_q) hv_seen <= fl_hv_by_hw_q;
      if (ecnt_q == 5'd1) ret_seen <= call_returned_q;
      fv_flash_word <= fv_rd ? {25'd0, fv_addr[8:2]} ^ 32'h3c3c_0000 ^
        {31'd0, corrupt && fv_addr[8:2] == 7'd5} : ~fv_flash_word;
      latch_word <= fv_rd ? {25'd0, latch_idx} ^ 32'h3c3c_0000 : ~latch_word;
    end
  end
endmodule
`default_nettype wire

// ===== fuse_read_row_program_calls_tb.sv
// Purpose: Self-checking bench of the fuse and row call engine.
// Assumes: Register bus is AXI4-Lite; memories come from frp_env_model.
// Notes: Expected results come from the bench's own rules model.
`timescale 1ns/1ps
`default_nettype none
`include "frp_consts.svh"
module fuse_read_row_program_calls_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic flash_wr_allowed = 1'b1, slow = 1'b0, prog_ok = 1'b1;
  logic corrupt = 1'b0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
  logic s_axil_rvalid, sram_req_q, sram_we_q, sram_ack, fuse_rd_q, fuse_ack;
  logic [1:0] s_axil_bresp, s_axil_rresp, resp;
  logic [31:0] s_axil_rdata, sram_addr_q, sram_wdata_q, sram_rdata;
  logic [31:0] fl_row_addr_q, fv_addr, fv_flash_word, latch_word, d, ex;
  logic [15:0] fuse_addr_q;
  logic [7:0] fuse_cell_intact;
  logic [6:0] latch_idx;
  logic [4:0] idx, c;
  logic fl_erase_start_q, fl_prog_start_q, fl_hv_by_hw_q, fl_stall_reads_q;
  logic fl_erase_done, fl_prog_done, fl_prog_ok, fv_rd, call_held_q;
  logic call_returned_q, ret_seen, hv_seen;
  logic [31:0] rnd = 32'h0cbf5efa;
  logic [31:0] exp_q [$];
  int miscompares = 0, checks = 0, i;
  logic [4:0] cases [5] = '{5'b11110, 5'b01111, 5'b10000, 5'b00100, 5'b10111};
  frp_call_core DUT (.*);
  frp_env_model u_env (.*);
  always #50 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    report_and_stop();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge sys_clk);
    s_axil_awaddr <= a;
    s_axil_wdata <= v;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      if (s_axil_bvalid) break;
    end
    resp = s_axil_bresp;
    s_axil_bready <= 1'b0;
    if (n == 100) hang();
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v);
    int n;
    @(posedge sys_clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid) break;
    end
    v = s_axil_rdata;
    resp = s_axil_rresp;
    s_axil_rready <= 1'b0;
    if (n == 100) hang();
  endtask
  // A second doorbell mid-call must be ignored while the channel is held.
  task automatic run(input logic [31:0] w, input logic poke);
    logic [31:0] s;
    int n;
    axw(`FRP_OFS_DATA, w);
    axw(`FRP_OFS_CTRL, 32'h1);
    repeat (3) @(posedge sys_clk);
    if (poke) axw(`FRP_OFS_CTRL, 32'h1);
    for (n = 0; n < 500; n++) begin
      axr(`FRP_OFS_STAT, s);
      if (s[0] === 1'b0) break;
    end
    if (n == 500) hang();
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    axr(`FRP_OFS_STAT, d);
    check("status", d, 32'h0);
    axw(8'h40, 32'h1);
    check("bresp", resp, `FRP_RESP_SLVERR);
    axr(8'h40, d);
    check("rdata", d, 32'h0);
    $display("register map done");
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      exp_q.push_back({8'ha0, 16'h0, ~(rnd[7:0] ^ 8'h5a)});
      idx = rnd[20:16];
      if (i[0]) begin
        u_env.mem[idx] = {8'h03, rnd[15:0], rnd[31:24]};
        run({25'h0, idx, 2'b00}, 1'b0);
        check("fuse_block", u_env.mem[idx], exp_q.pop_front());
      end else begin
        run({8'h03, rnd[15:0], 8'h01}, 1'b0);
        axr(`FRP_OFS_DATA, d);
        check("fuse_data", d, exp_q.pop_front());
      end
    end
    run({8'h07, 16'h0, 8'h01}, 1'b0);
    axr(`FRP_OFS_DATA, d);
    check("opcode", d, `FRP_ERR_OPCODE);
    run({8'h05, 16'h0, 8'h01}, 1'b0);
    axr(`FRP_OFS_DATA, d);
    check("direct_row", d, `FRP_ERR_PARAM);
    $display("fuse calls done");
    for (i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      c = cases[i];
      idx = rnd[20:16];
      flash_wr_allowed <= c[2];
      prog_ok <= c[1];
      corrupt <= c[0];
      slow <= i[0];
      ex = !c[2] ? `FRP_ERR_PROT : !c[1] ? `FRP_ERR_PROG :
        (c[3] && c[0]) ? `FRP_ERR_VERIFY : `FRP_RES_OK;
      u_env.mem[idx] = {8'h05, 8'h00, c[4] ? 8'h01 : 8'h02, 5'h0, i[1], i[0],
        1'b0};
      u_env.mem[idx + 1] = {8'h00, c[3] ? 8'h01 : 8'h00, 16'h0};
      u_env.mem[idx + 2] = {16'h1000, rnd[15:0]};
      run({25'h0, idx, 2'b00}, !c[4]);
      check("row", u_env.mem[idx], ex);
      if (c[2]) begin
        check("hv", hv_seen, i[0]);
        check("ret", ret_seen, !c[4]);
      end
    end
    $display("row calls done");
    report_and_stop();
  end
endmodule
`default_nettype wire
